// *** hdl/camd_decoder.sv ***
// Sequencer that fetches operand bytes and forms effective addresses
`timescale 1ns/10ps
`default_nettype none
module camd_decoder
   import camd_pkg::*;
(
   input  wire logic        clk_i,        // 40 MHz core clock
   input  wire logic        srst_i,       // Sync reset, active high
   input  wire logic        op_valid_i,   // Opcode byte offered
   input  wire logic [7:0]  op_byte_i,    // Opcode byte
   input  wire logic [7:0]  idx_x_i,      // X index register
   input  wire logic [7:0]  idx_y_i,      // Y index register
   input  wire logic        wake_i,       // Interrupt ends wait/halt
   output logic             op_ready_o,   // Decoder accepts opcode
   output logic             mem_req_o,    // Byte read request (program or pointer)
   output logic [15:0]      mem_addr_o,   // Read address (pointer reads)
   output logic             mem_seq_o,    // 1: next program byte, 0: pointer read
   input  wire logic        mem_ack_i,    // Byte returned this cycle
   input  wire logic [7:0]  mem_data_i,   // Returned byte
   output logic             ea_valid_o,   // Result pulse
   output logic [15:0]      ea_o,         // Effective address
   output logic [7:0]       imm_o,        // Immediate operand
   output logic             imm_flag_o,   // Result is a literal
   output logic             illegal_o,    // Long form on RMW opcode
   output logic [3:0]       mode_o,       // Decoded mode code
   output logic [1:0]       imask_o,      // Core interrupt mask level
   output logic             wait_o,       // Low-power wait state
   output logic             halt_o        // Oscillator stopped
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      camd_state_t st;
      camd_mode_t  mode;
      logic        use_y;
      logic [15:0] opnd;
      logic [7:0]  ptr;
      logic        ea_v;
      logic [15:0] ea;
      logic [7:0]  imm;
      logic        imm_f;
      logic        ill;
      logic [1:0]  imask;
      logic        wt;
      logic        hl;
   } camd_st_t;

   camd_st_t s_reg, s_next;
   camd_op_if opif ();

   assign opif.opcode = op_byte_i;

   camd_opdec u_dec (
      .op (opif)
   );

   // Unsigned index sum; word wide so short offsets reach 1FE
   function automatic logic [15:0] idx_add(input logic [15:0] base, input logic y,
                                           input logic [7:0] x, input logic [7:0] yv);
      idx_add = base + {8'h00, (y ? yv : x)};
   endfunction : idx_add

   function automatic logic is_long(input camd_mode_t m);
      is_long = (m == CAMD_M_DIRL) || (m == CAMD_M_IXL) || (m == CAMD_M_INDL);
   endfunction : is_long

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next      = s_reg;
      s_next.ea_v = 1'b0;
      case (s_reg.st)
         CAMD_S_IDLE: begin
            if (s_reg.wt && wake_i) begin
               s_next.wt = 1'b0;
               s_next.hl = 1'b0;
            end else if (op_valid_i && !s_reg.wt) begin
               s_next.mode  = opif.mode;
               s_next.use_y = opif.use_y;
               s_next.opnd  = 16'h0000;
               s_next.imm_f = 1'b0;
               s_next.ill   = 1'b0;
               if (opif.rmw && is_long(opif.mode)) begin
                  s_next.ill  = 1'b1;
                  s_next.ea_v = 1'b1;
               end else begin
                  case (opif.mode)
                     CAMD_M_INH: begin
                        s_next.ea_v = 1'b1;
                        s_next.ea   = 16'h0000;
                        case (opif.kind)
                           CAMD_K_MSET: s_next.imask = IMASK_SET;
                           CAMD_K_MCLR: s_next.imask = IMASK_CLR;
                           CAMD_K_LOWP: begin
                              s_next.wt = 1'b1;
                              s_next.hl = opif.halt;
                           end
                           default: s_next.imask = s_reg.imask;
                        endcase
                     end
                     CAMD_M_IX0: begin
                        s_next.ea   = idx_add(16'h0000, opif.use_y, idx_x_i, idx_y_i)
                                      & PAGE0_MASK;
                        s_next.ea_v = 1'b1;
                     end
                     CAMD_M_BAD: begin
                        s_next.ill  = 1'b1;
                        s_next.ea_v = 1'b1;
                     end
                     default: s_next.st = CAMD_S_OP1;
                  endcase
               end
            end
         end
         CAMD_S_OP1: begin
            if (mem_ack_i) begin
               case (s_reg.mode)
                  CAMD_M_IMM: begin
                     s_next.imm   = mem_data_i;
                     s_next.imm_f = 1'b1;
                     s_next.st    = CAMD_S_DONE;
                  end
                  CAMD_M_DIRS: begin
                     s_next.ea = {8'h00, mem_data_i};
                     s_next.st = CAMD_S_DONE;
                  end
                  CAMD_M_IXS: begin
                     s_next.ea = idx_add({8'h00, mem_data_i}, s_reg.use_y,
                                         idx_x_i, idx_y_i);
                     s_next.st = CAMD_S_DONE;
                  end
                  CAMD_M_INDS, CAMD_M_INDL: begin
                     s_next.ptr = mem_data_i;
                     s_next.st  = CAMD_S_PTR1;
                  end
                  default: begin
                     s_next.opnd = {mem_data_i, 8'h00};
                     s_next.st   = CAMD_S_OP2;
                  end
               endcase
            end
         end
         CAMD_S_OP2: begin
            if (mem_ack_i) begin
               if (s_reg.mode == CAMD_M_IXL) begin
                  s_next.ea = idx_add({s_reg.opnd[15:8], mem_data_i}, s_reg.use_y,
                                      idx_x_i, idx_y_i);
               end else begin
                  s_next.ea = {s_reg.opnd[15:8], mem_data_i};
               end
               s_next.st = CAMD_S_DONE;
            end
         end
         CAMD_S_PTR1: begin
            if (mem_ack_i) begin
               if (s_reg.mode == CAMD_M_INDS) begin
                  s_next.ea = {8'h00, mem_data_i};
                  s_next.st = CAMD_S_DONE;
               end else begin
                  s_next.opnd = {mem_data_i, 8'h00};
                  s_next.st   = CAMD_S_PTR2;
               end
            end
         end
         CAMD_S_PTR2: begin
            if (mem_ack_i) begin
               s_next.ea = {s_reg.opnd[15:8], mem_data_i};
               s_next.st = CAMD_S_DONE;
            end
         end
         CAMD_S_DONE: begin
            s_next.ea_v = 1'b1;
            s_next.st   = CAMD_S_IDLE;
         end
         default: s_next.st = CAMD_S_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_reg       <= '0;
         s_reg.st    <= CAMD_S_IDLE;
         s_reg.mode  <= CAMD_M_INH;
         s_reg.imask <= IMASK_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Pointer reads address page zero; the second byte follows at ptr+1
   always_comb begin
      mem_req_o  = (s_reg.st == CAMD_S_OP1) || (s_reg.st == CAMD_S_OP2) ||
                   (s_reg.st == CAMD_S_PTR1) || (s_reg.st == CAMD_S_PTR2);
      mem_seq_o  = (s_reg.st == CAMD_S_OP1) || (s_reg.st == CAMD_S_OP2);
      mem_addr_o = 16'h0000;
      if (s_reg.st == CAMD_S_PTR1) begin
         mem_addr_o = {8'h00, s_reg.ptr};
      end else if (s_reg.st == CAMD_S_PTR2) begin
         mem_addr_o = {8'h00, s_reg.ptr + 8'h01};
      end
   end

   assign op_ready_o = (s_reg.st == CAMD_S_IDLE) && !s_reg.wt;
   assign ea_valid_o = s_reg.ea_v;
   assign ea_o       = s_reg.ea;
   assign imm_o      = s_reg.imm;
   assign imm_flag_o = s_reg.imm_f;
   assign illegal_o  = s_reg.ill;
   assign mode_o     = s_reg.mode;
   assign imask_o    = s_reg.imask;
   assign wait_o     = s_reg.wt;
   assign halt_o     = s_reg.hl;
endmodule : camd_decoder
`default_nettype wire

// *** hdl/camd_pkg.sv ***
// Constants and types for the addressing-mode decoder
package camd_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] PAGE0_MASK = 16'h00FF;
   localparam logic [1:0]  IMASK_SET  = 2'h3;
   localparam logic [1:0]  IMASK_CLR  = 2'h0;
   localparam logic [1:0]  IMASK_RST  = 2'h3;

   // Addressing mode codes as presented by the opcode decode
   typedef enum logic [3:0] {
      CAMD_M_INH   = 4'h0,
      CAMD_M_IMM   = 4'h1,
      CAMD_M_DIRS  = 4'h2,
      CAMD_M_DIRL  = 4'h3,
      CAMD_M_IX0   = 4'h4,
      CAMD_M_IXS   = 4'h5,
      CAMD_M_IXL   = 4'h6,
      CAMD_M_INDS  = 4'h7,
      CAMD_M_INDL  = 4'h8,
      CAMD_M_BAD   = 4'hF
   } camd_mode_t;

   typedef enum logic [1:0] {
      CAMD_K_NONE = 2'h0,
      CAMD_K_MSET = 2'h1,
      CAMD_K_MCLR = 2'h2,
      CAMD_K_LOWP = 2'h3
   } camd_kind_t;

   typedef enum logic [2:0] {
      CAMD_S_IDLE = 3'b000,
      CAMD_S_OP1  = 3'b001,
      CAMD_S_OP2  = 3'b011,
      CAMD_S_PTR1 = 3'b010,
      CAMD_S_PTR2 = 3'b110,
      CAMD_S_DONE = 3'b111
   } camd_state_t;
endpackage : camd_pkg

// *** hdl/camd_op_if.sv ***
// Interface carrying decoded opcode fields to the sequencer
`timescale 1ns/10ps
`default_nettype none
interface camd_op_if;
   import camd_pkg::*;
   logic [7:0]  opcode;
   camd_mode_t  mode;
   logic        use_y;
   logic        rmw;
   camd_kind_t  kind;
   logic        halt;
   modport dec (input opcode, output mode, output use_y, output rmw, output kind, output halt);
   modport seq (output opcode, input mode, input use_y, input rmw, input kind, input halt);
endinterface : camd_op_if
`default_nettype wire

// *** hdl/camd_opdec.sv ***
// Opcode classifier: addressing mode, index select, instruction class
`timescale 1ns/10ps
`default_nettype none
module camd_opdec
   import camd_pkg::*;
(
   camd_op_if.dec op      // Opcode in, fields out
);
   // High nibble picks the mode, low nibble the operation (simplified map)
   always_comb begin
      op.use_y = op.opcode[7] & op.opcode[3];
      op.rmw   = ~op.opcode[7] & (op.opcode[3:0] != 4'h6);
      op.kind  = CAMD_K_NONE;
      op.halt  = 1'b0;
      case (op.opcode[7:4])
         4'h0: op.mode = CAMD_M_INDS;
         4'h1: op.mode = CAMD_M_DIRS;
         4'h2: op.mode = CAMD_M_IMM;
         4'h3: op.mode = CAMD_M_DIRS;
         4'h4, 4'h5: op.mode = CAMD_M_INH;
         4'h6: op.mode = CAMD_M_IXS;
         4'h7: op.mode = CAMD_M_IX0;
         4'h8: begin
            op.mode = CAMD_M_INH;
            case (op.opcode[3:0])
               4'h0: op.kind = CAMD_K_MSET;
               4'h1: op.kind = CAMD_K_MCLR;
               4'h2: op.kind = CAMD_K_LOWP;
               4'h3: begin
                  op.kind = CAMD_K_LOWP;
                  op.halt = 1'b1;
               end
               default: op.kind = CAMD_K_NONE;
            endcase
         end
         4'h9: op.mode = CAMD_M_INDL;
         4'hA: op.mode = CAMD_M_IMM;
         4'hB: op.mode = CAMD_M_DIRS;
         4'hC: op.mode = CAMD_M_DIRL;
         4'hD: op.mode = CAMD_M_IXL;
         4'hE: op.mode = CAMD_M_IXS;
         4'hF: op.mode = CAMD_M_IX0;
         default: op.mode = CAMD_M_BAD;
      endcase
   end
endmodule : camd_opdec
`default_nettype wire

// *** verif/camd_decoder_asserts.sv ***
// Port-level checks on the addressing-mode decoder
`timescale 1ns/10ps
`default_nettype none
module camd_decoder_asserts
   import camd_pkg::*;
(
   input wire logic        clk_i,       // Clock
   input wire logic        srst_i,      // Reset
   input wire logic        op_valid_i,  // Offer
   input wire logic [7:0]  op_byte_i,   // Opcode
   input wire logic        op_ready_o,  // Ready
   input wire logic        mem_req_o,   // Fetch
   input wire logic [15:0] mem_addr_o,  // Address
   input wire logic        mem_seq_o,   // Stream
   input wire logic        mem_ack_i,   // Ack
   input wire logic        ea_valid_o,  // Result
   input wire logic [15:0] ea_o,        // Address out
   input wire logic        imm_flag_o,  // Literal
   input wire logic        illegal_o,   // Refused form
   input wire logic [3:0]  mode_o,      // Mode
   input wire logic [1:0]  imask_o,     // Mask
   input wire logic        wait_o,      // Wait
   input wire logic        halt_o       // Halt
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   sequence s_take(logic [7:0] b);
      op_valid_i && op_ready_o && op_byte_i == b;
   endsequence
   sequence s_take_n(logic [3:0] n);
      op_valid_i && op_ready_o && op_byte_i[7:4] == n;
   endsequence
   sequence s_take_rmw;
      op_valid_i && op_ready_o && !op_byte_i[7] && op_byte_i[3:0] != 4'h6;
   endsequence
   sequence s_done(logic [3:0] m);
      ea_valid_o && mode_o == m;
   endsequence
   // Only the cycle after the take: a next opcode may be taken back to back
   AST_INH_NOFETCH: assert property (s_take_n(4'h4) |=> (!mem_req_o && ea_valid_o))
      else $error("inherent opcode fetched a byte");
   AST_IX0: assert property (
      s_take_n(4'h7) |=> !mem_req_o ##[0:1] (ea_valid_o && ea_o[15:8] == 8'h00))
      else $error("no-offset indexed result wrong");
   AST_PAGE0: assert property (
      ea_valid_o && (mode_o == CAMD_M_DIRS || mode_o == CAMD_M_INDS) |-> ea_o[15:8] == 8'h00)
      else $error("short form left page zero");
   AST_RMW_SHORT: assert property (
      s_take_rmw |=> illegal_o || !(mode_o inside {CAMD_M_DIRL, CAMD_M_IXL, CAMD_M_INDL}))
      else $error("long form accepted on read-modify-write opcode");
   AST_IXS_RANGE: assert property (s_done(CAMD_M_IXS) |-> ea_o <= 16'h01FE)
      else $error("short indexed beyond 1FE");
   AST_IMM: assert property (s_done(CAMD_M_IMM) |-> imm_flag_o)
      else $error("immediate not flagged literal");
   AST_HOLD: assert property (
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_seq_o))
      else $error("fetch request dropped or changed");
   AST_PTR: assert property (mem_req_o && !mem_seq_o |-> mem_addr_o[15:8] == 8'h00)
      else $error("pointer read outside page zero");
   AST_MASK_SET: assert property (s_take(8'h80) |-> ##[1:2] imask_o == IMASK_SET)
      else $error("mask not raised");
   AST_MASK_CLR: assert property (s_take(8'h81) |-> ##[1:2] imask_o == IMASK_CLR)
      else $error("mask not cleared");
   AST_WAIT: assert property (s_take(8'h82) |-> ##[1:2] (wait_o && !op_ready_o))
      else $error("wait not entered");
   AST_HALT: assert property (s_take(8'h83) |-> ##[1:2] (halt_o && !op_ready_o))
      else $error("halt not entered");
endmodule : camd_decoder_asserts
bind camd_decoder camd_decoder_asserts u_chk (
   .clk_i      (clk_i),
   .srst_i     (srst_i),
   .op_valid_i (op_valid_i),
   .op_byte_i  (op_byte_i),
   .op_ready_o (op_ready_o),
   .mem_req_o  (mem_req_o),
   .mem_addr_o (mem_addr_o),
   .mem_seq_o  (mem_seq_o),
   .mem_ack_i  (mem_ack_i),
   .ea_valid_o (ea_valid_o),
   .ea_o       (ea_o),
   .imm_flag_o (imm_flag_o),
   .illegal_o  (illegal_o),
   .mode_o     (mode_o),
   .imask_o    (imask_o),
   .wait_o     (wait_o),
   .halt_o     (halt_o)
);
`default_nettype wire

// *** verif/camd_mem_model.sv ***
// Behavioural program and data memory on the core bus
`timescale 1ns/10ps
`default_nettype none
module camd_mem_model (
   input  wire logic        clk_i,   // Clock
   input  wire logic        srst_i,  // Reset
   input  wire logic        req_i,   // Read request
   input  wire logic        seq_i,   // Program stream
   input  wire logic [15:0] addr_i,  // Pointer address
   input  wire logic [7:0]  key_i,   // Content scramble
   input  wire logic        stall_i, // Slow answer
   output logic             ack_o,   // Byte valid
   output logic [7:0]       data_o,  // Byte
   output logic [15:0]      pc_o     // Bytes streamed
);
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ack_o  <= 1'b0;
         data_o <= 8'hA5;
         pc_o   <= 16'h0000;
      end else if (req_i && !ack_o && !stall_i) begin
         ack_o  <= 1'b1;
         data_o <= seq_i ? (pc_o[7:0] ^ key_i) : (addr_i[7:0] ^ key_i ^ 8'h5A);
         pc_o   <= pc_o + {15'h0000, seq_i};
      end else begin
         ack_o  <= 1'b0;
         // Released bus must not look like a held byte
         data_o <= ~data_o;
      end
   end
endmodule : camd_mem_model
`default_nettype wire

// *** verif/camd_decoder_bench.sv ***
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/10ps
`default_nettype none
module camd_decoder_bench;
   import camd_pkg::*;
   logic        clk_i = 1'b0, srst_i = 1'b1, op_valid_i = 1'b0, wake_i = 1'b0;
   logic [7:0]  op_byte_i = 8'h00, idx_x_i = 8'h00, idx_y_i = 8'h00, key_i = 8'h00;
   logic        stall_i = 1'b0, slow_q = 1'b0, op_ready_o, mem_req_o, mem_seq_o, mem_ack_i;
   logic [15:0] mem_addr_o, ea_o, pc_w, pc_q = 16'h0000;
   logic [7:0]  mem_data_i, imm_o, v;
   logic        ea_valid_o, imm_flag_o, illegal_o, wait_o, halt_o;
   logic [3:0]  mode_o;
   logic [1:0]  imask_o;
   logic [31:0] lfsr_q = 32'hDCFDE4D8;
   int          err_total = 0, checks_done = 0;
   camd_decoder uut (.clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
      .op_byte_i(op_byte_i), .idx_x_i(idx_x_i), .idx_y_i(idx_y_i), .wake_i(wake_i),
      .op_ready_o(op_ready_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
      .mem_seq_o(mem_seq_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
      .ea_valid_o(ea_valid_o), .ea_o(ea_o), .imm_o(imm_o), .imm_flag_o(imm_flag_o),
      .illegal_o(illegal_o), .mode_o(mode_o), .imask_o(imask_o), .wait_o(wait_o),
      .halt_o(halt_o));
   camd_mem_model u_mem (.clk_i(clk_i), .srst_i(srst_i), .req_i(mem_req_o), .seq_i(mem_seq_o),
      .addr_i(mem_addr_o), .key_i(key_i), .stall_i(stall_i), .ack_o(mem_ack_i),
      .data_o(mem_data_i), .pc_o(pc_w));
   always #12.5 clk_i = ~clk_i;
   // Alternate stalls make the first answer of a fetch late when it meets a stall
   always @(negedge clk_i) stall_i <= slow_q & ~stall_i;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[7:0];
   endfunction : rnd
   function logic [7:0] prog(input logic [15:0] p);
      return p[7:0] ^ key_i;
   endfunction : prog
   function logic [7:0] dat(input logic [15:0] a);
      return a[7:0] ^ key_i ^ 8'h5A;
   endfunction : dat
   task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task end_sim;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   task issue(input logic [7:0] op);
      int n;
      op_byte_i = op;
      op_valid_i = 1'b1;
      n = 0;
      while (op_ready_o !== 1'b1 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      @(negedge clk_i);
      op_valid_i = 1'b0;
   endtask : issue
   task run_op(input logic [7:0] op);
      logic [15:0] ea, ix, b0, b1;
      camd_mode_t  md;
      int          len, n;
      ix = {8'h00, (op[7] & op[3]) ? idx_y_i : idx_x_i};
      b0 = {8'h00, prog(pc_q)};
      b1 = {8'h00, prog(pc_q + 16'h0001)};
      len = 1;
      case (op[7:4])
         4'h0: begin ea = {8'h00, dat(b0)}; md = CAMD_M_INDS; end
         4'h1, 4'h3, 4'hB: begin ea = b0; md = CAMD_M_DIRS; end
         4'h2, 4'hA: begin ea = b0; md = CAMD_M_IMM; end
         4'h6, 4'hE: begin ea = ix + b0; md = CAMD_M_IXS; end
         4'h7, 4'hF: begin ea = ix; md = CAMD_M_IX0; len = 0; end
         4'h9: begin ea = {dat(b0), dat(b0 + 16'h0001)}; md = CAMD_M_INDL; end
         4'hC: begin ea = {b0[7:0], b1[7:0]}; md = CAMD_M_DIRL; len = 2; end
         4'hD: begin ea = {b0[7:0], b1[7:0]} + ix; md = CAMD_M_IXL; len = 2; end
         default: begin ea = 16'h0000; md = CAMD_M_INH; len = 0; end
      endcase
      issue(op);
      n = 0;
      while (ea_valid_o !== 1'b1 && n < 60) begin
         @(negedge clk_i);
         n++;
      end
      cmp("result", 16'h0001, {15'h0000, ea_valid_o});
      cmp("mode", {12'h000, md}, {12'h000, mode_o});
      if (md == CAMD_M_IMM) cmp("literal", ea, {8'h00, imm_o});
      else if (md != CAMD_M_INH) cmp("address", ea, ea_o);
      cmp("literal flag", {15'h0000, md == CAMD_M_IMM}, {15'h0000, imm_flag_o});
      cmp("illegal", 16'h0000, {15'h0000, illegal_o});
      pc_q = pc_q + 16'(len);
      cmp("bytes", pc_q, pc_w);
   endtask : run_op
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(negedge clk_i);
      srst_i = 1'b0;
      cmp("mask reset", {14'h0000, IMASK_RST}, {14'h0000, imask_o});
      idx_x_i = 8'hFF;
      key_i = 8'hFF;
      run_op(8'h60);
      idx_x_i = 8'h00;
      idx_y_i = 8'hFF;
      key_i = pc_q[7:0] ^ 8'hFF;
      run_op(8'hE8);
      run_op(8'h81);
      cmp("mask clear", {14'h0000, IMASK_CLR}, {14'h0000, imask_o});
      run_op(8'h80);
      cmp("mask set", {14'h0000, IMASK_SET}, {14'h0000, imask_o});
      for (int i = 0; i < 2; i++) begin
         issue(8'h82 + 8'(i));
         repeat (2) @(negedge clk_i);
         cmp("low power", 16'h0001, {15'h0000, i ? halt_o : wait_o});
         op_byte_i = 8'h40;
         op_valid_i = 1'b1;
         repeat (4) @(negedge clk_i);
         cmp("refused", 16'h0000, {15'h0000, op_ready_o});
         op_valid_i = 1'b0;
         wake_i = 1'b1;
         @(negedge clk_i);
         wake_i = 1'b0;
         repeat (2) @(negedge clk_i);
         cmp("woken", 16'h0000, {15'h0000, wait_o | halt_o});
      end
      repeat (80) begin
         v = rnd();
         idx_x_i = v;
         v = rnd();
         idx_y_i = v;
         v = rnd();
         key_i = v;
         slow_q = v[0];
         v = rnd();
         if (v[7:4] == 4'h8) v[4] = 1'b1;
         run_op(v);
      end
      end_sim();
   end
   initial begin
      #(25 * 20000);
      err_total++;
      end_sim();
   end
endmodule : camd_decoder_bench
`default_nettype wire
